//--- include/wake_pkg.sv
// Package: wake-time types, PHY table constants and state codes
package wake_pkg;

  // Wake times are unsigned integers in units of 10 ns (one sys_clk cycle)
  localparam int WAKE_W = 16;
  typedef logic [WAKE_W-1:0] wake_t;

  // Time unit and per-PHY minimum transmit wake times, in ns as printed in us
  localparam int CLK_PERIOD_NS = 10;
  localparam int TW_100BASE_TX_NS = 30000;
  localparam int TW_1000BASE_T_NS = 16500;
  localparam int TW_1000BASE_KX_NS = 13260;
  localparam int TW_XGXS_TX_NS = 12380;
  localparam int TW_XGXS_RX_NS = 2880;
  localparam int TW_10GBASE_T_C1_NS = 7360;
  localparam int TW_10GBASE_T_C2_NS = 4480;
  localparam int TW_10GBASE_KX4_NS = 12380;
  localparam int TW_10GBASE_KR_C1_NS = 15380;
  localparam int TW_10GBASE_KR_C2_NS = 17380;
  localparam int FAULT_WINDOW_MS = 10;
  localparam int FAULT_WINDOW_CYCLES = FAULT_WINDOW_MS * 1000000 / CLK_PERIOD_NS;
  localparam int XGXS_EXTRA_CYCLES = (TW_XGXS_TX_NS - TW_XGXS_RX_NS) / CLK_PERIOD_NS;

  // PHY type selector
  typedef enum logic [2:0] {
    PHY_100BASE_TX = 3'h0,
    PHY_1000BASE_T = 3'h1,
    PHY_1000BASE_KX = 3'h2,
    PHY_XGXS = 3'h3,
    PHY_10GBASE_T = 3'h4,
    PHY_10GBASE_KX4 = 3'h5,
    PHY_10GBASE_KR = 3'h6
  } phy_type_e;

  // Transmit negotiation states
  typedef enum logic [5:0] {
    TX_RUNNING = 6'h01,
    TX_LOCAL_CHANGE = 6'h02,
    TX_REMOTE_CHANGE = 6'h04,
    TX_UPDATE = 6'h08,
    TX_REALLOC = 6'h10,
    TX_MIRROR = 6'h20
  } tx_state_e;

  // Receive negotiation states
  typedef enum logic [3:0] {
    RX_RUNNING = 4'h1,
    RX_CHANGE = 4'h2,
    RX_REALLOC = 4'h4,
    RX_UPDATE = 4'h8
  } rx_state_e;

  // Values received from the peer through the discovery protocol
  typedef struct packed {
    wake_t rem_rx_value;
    wake_t rem_tx_echo;
    wake_t rem_tx_value;
    wake_t rem_rx_echo;
  } remote_s;

  // Values this end advertises to the peer
  typedef struct packed {
    wake_t loc_tx_value;
    wake_t loc_rx_echo;
    wake_t loc_rx_value;
    wake_t loc_tx_echo;
  } local_s;

endpackage : wake_pkg

//--- logic/wake_hold_timer.sv
// Down-counter holding data back after low-power idle ends
`timescale 1ns/1ns
`default_nettype none
module wake_hold_timer (
  input wire logic sys_clk, // System clock
  input wire logic reset, // Synchronous reset
  input wire logic start, // Low-power idle just ended
  input wire logic [wake_pkg::WAKE_W:0] wait_cycles, // Cycles to hold
  output logic data_ok // Frames may be sent
);

  logic [wake_pkg::WAKE_W:0] count_reg;
  logic [wake_pkg::WAKE_W:0] count_next;
  logic ok_reg;
  logic ok_next;

  always_comb begin
    count_next = count_reg;
    ok_next = ok_reg;
    if (start) begin
      count_next = wait_cycles;
      ok_next = 1'b0;
    end else if (count_reg != '0) begin
      count_next = count_reg - 1'b1;
      ok_next = (count_reg == {{wake_pkg::WAKE_W{1'b0}}, 1'b1});
    end else begin
      ok_next = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      count_reg <= '0;
      ok_reg <= 1'b1;
    end else begin
      count_reg <= count_next;
      ok_reg <= ok_next;
    end
  end

  assign data_ok = ok_reg;

endmodule : wake_hold_timer
`default_nettype wire

//--- logic/wake_min_table.sv
// Per-PHY minimum transmit wake time lookup
`timescale 1ns/1ns
`default_nettype none
module wake_min_table (
  input wire logic [2:0] phy_type, // PHY type selector
  input wire logic use_case2, // Timing case 2 selected (10GBASE-T, 10GBASE-KR)
  output logic [wake_pkg::WAKE_W-1:0] min_wake // Minimum wake, cycles
);

  function automatic logic [wake_pkg::WAKE_W-1:0] ns_to_cyc(input int ns);
    ns_to_cyc = wake_pkg::WAKE_W'((ns + wake_pkg::CLK_PERIOD_NS - 1) / wake_pkg::CLK_PERIOD_NS);
  endfunction : ns_to_cyc

  always_comb begin
    if (phy_type == wake_pkg::PHY_1000BASE_T) begin
      min_wake = ns_to_cyc(wake_pkg::TW_1000BASE_T_NS); // RL13
    end else if (phy_type == wake_pkg::PHY_1000BASE_KX) begin
      min_wake = ns_to_cyc(wake_pkg::TW_1000BASE_KX_NS);
    end else if (phy_type == wake_pkg::PHY_XGXS) begin
      min_wake = ns_to_cyc(wake_pkg::TW_XGXS_TX_NS);
    end else if (phy_type == wake_pkg::PHY_10GBASE_T) begin
      min_wake = use_case2 ? ns_to_cyc(wake_pkg::TW_10GBASE_T_C2_NS)
                           : ns_to_cyc(wake_pkg::TW_10GBASE_T_C1_NS); // RL14
    end else if (phy_type == wake_pkg::PHY_10GBASE_KX4) begin
      min_wake = ns_to_cyc(wake_pkg::TW_10GBASE_KX4_NS);
    end else if (phy_type == wake_pkg::PHY_10GBASE_KR) begin
      min_wake = use_case2 ? ns_to_cyc(wake_pkg::TW_10GBASE_KR_C2_NS)
                           : ns_to_cyc(wake_pkg::TW_10GBASE_KR_C1_NS); // RL15
    end else begin
      min_wake = ns_to_cyc(wake_pkg::TW_100BASE_TX_NS); // RL13
    end
  end

endmodule : wake_min_table
`default_nettype wire

//--- logic/wake_negotiation.sv
// Wake-time negotiation: transmit and receive machines, wake gating
// ****************************************************************
// Summary of operation
// [RL1] Tx synced when advertised equals peer echo
// [RL2] Tx leaves RUNNING to LOCAL CHANGE on request
// [RL3] Lower proposal or synced goes to TX UPDATE
// [RL4] Peer request honoured only while synced
// [RL5] TX UPDATE loads advertised with proposal
// [RL6] Larger proposal reallocates resolved value
// [RL7] Mirror state echoes peer request, then RUNNING
// [RL8] Rx synced when requested equals peer echo
// [RL9] Rx enters CHANGE on request or advertisement change
// [RL10] Smaller proposal reallocates resolved, then RX UPDATE
// [RL11] RX UPDATE sets request, mirror refreshes echo
// [RL12] Leave idle by sending IDLE; PHY wakes
// [RL13] Transmit wake never below PHY minimum
// [RL14] 10GBASE-T case 2 needs sleep done, no fault
// [RL15] Timing case selected per PHY mode
// [RL16] DTE stop enable adds XGXS wake difference
// [RL17] PHY stop enable needs extra remote wake
// [RL18] Extender inserted changes no timing
// [RL19] Wait resolved wake before any frame
// [RL20] Resolved values reset to PHY minimum
// [RL21] One transition per cycle, unsigned wake units
// ****************************************************************
`timescale 1ns/1ns
`default_nettype none
module wake_negotiation #(
  parameter int FAULT_WINDOW = wake_pkg::FAULT_WINDOW_CYCLES // Fault quiet window, cycles
) (
  input wire logic sys_clk, // System clock, 100 MHz
  input wire logic reset, // Synchronous reset, active high
  input wire logic [2:0] phy_type, // PHY type, phy_type_e code
  input wire logic phy_master, // 1000BASE-T master mode
  input wire logic phy_fec, // 10GBASE-KR with FEC
  input wire logic sleep_done, // Sleep signal fully sent
  input wire logic local_fault, // PHY reports local fault
  input wire logic dte_extender_stop_enable, // DTE extender may halt
  input wire logic phy_extender_stop_req, // Ask to let PHY extender halt
  input wire logic local_system_change, // Local wake change request
  input wire logic [wake_pkg::WAKE_W-1:0] new_tx_value, // Proposed tx wake
  input wire logic [wake_pkg::WAKE_W-1:0] new_rx_value, // Proposed rx wake
  input wire wake_pkg::remote_s remote, // Values from peer
  input wire logic lpi_request, // Client asks for low-power idle
  output wake_pkg::local_s local_vals, // Values advertised to peer
  output logic [wake_pkg::WAKE_W-1:0] resolved_tx, // Resolved tx wake
  output logic [wake_pkg::WAKE_W-1:0] resolved_rx, // Resolved rx wake
  output logic phy_extender_stop_enable, // PHY extender may halt
  output logic send_lpi, // Assert LPI, else normal IDLE
  output logic data_allowed, // Frames may be sent
  output logic tx_in_sync, // Tx machine in sync
  output logic rx_in_sync // Rx machine in sync
);

  typedef logic [wake_pkg::WAKE_W-1:0] w_t;

  // Elaboration-time refusal of a window the fault counter cannot time
  if (FAULT_WINDOW < 1) begin : g_bad_window
    $error("FAULT_WINDOW must be at least one cycle");
  end

  // ****************************************************************
  // PHY minimum and timing case
  // ****************************************************************
  logic [31:0] fault_cnt_reg;
  logic [31:0] fault_cnt_next;
  logic use_case2;
  w_t phy_min;

  always_comb begin
    fault_cnt_next = fault_cnt_reg;
    if (local_fault) begin
      fault_cnt_next = 32'(FAULT_WINDOW);
    end else if (fault_cnt_reg != 32'h0) begin
      fault_cnt_next = fault_cnt_reg - 32'h1;
    end
  end

  always_comb begin
    if (phy_type == wake_pkg::PHY_10GBASE_T) begin
      use_case2 = sleep_done && (fault_cnt_reg == 32'h0) && !local_fault; // RL14
    end else if (phy_type == wake_pkg::PHY_1000BASE_T) begin
      use_case2 = !phy_master; // RL15
    end else begin
      use_case2 = phy_fec; // RL15
    end
  end

  // Extender inserted: same table, no timing change
  wake_min_table u_table ( // RL18
    .phy_type(phy_type),
    .use_case2(use_case2),
    .min_wake(phy_min)
  );

  function automatic w_t floor_min(input w_t v, input w_t m);
    floor_min = (v < m) ? m : v;
  endfunction : floor_min

  // ****************************************************************
  // Transmit machine
  // ****************************************************************
  wake_pkg::tx_state_e tx_state_reg;
  wake_pkg::tx_state_e tx_state_next;
  w_t tx_temp_reg;
  w_t tx_temp_next;
  w_t loc_tx_reg;
  w_t loc_tx_next;
  w_t rx_echo_reg;
  w_t rx_echo_next;
  w_t res_tx_reg;
  w_t res_tx_next;
  w_t rem_rx_seen_reg;
  w_t rem_rx_seen_next;
  logic tx_sync;

  assign tx_sync = (loc_tx_reg == remote.rem_tx_echo); // RL1

  always_comb begin
    tx_state_next = tx_state_reg;
    tx_temp_next = tx_temp_reg;
    loc_tx_next = loc_tx_reg;
    rx_echo_next = rx_echo_reg;
    res_tx_next = res_tx_reg;
    rem_rx_seen_next = rem_rx_seen_reg;
    case (tx_state_reg) // RL21
      wake_pkg::TX_RUNNING: begin
        if (local_system_change) begin
          tx_state_next = wake_pkg::TX_LOCAL_CHANGE; // RL2
          tx_temp_next = floor_min(new_tx_value, phy_min); // RL13
        end else if (remote.rem_rx_value != rem_rx_seen_reg && tx_sync) begin
          tx_state_next = wake_pkg::TX_REMOTE_CHANGE; // RL4
          rem_rx_seen_next = remote.rem_rx_value;
          tx_temp_next = floor_min(new_tx_value, phy_min);
        end
      end
      wake_pkg::TX_LOCAL_CHANGE: begin
        if (tx_temp_reg < loc_tx_reg || tx_sync) begin
          tx_state_next = wake_pkg::TX_UPDATE; // RL3
          loc_tx_next = tx_temp_reg; // RL5
        end else begin
          tx_state_next = wake_pkg::TX_RUNNING; // RL3
        end
      end
      wake_pkg::TX_REMOTE_CHANGE: begin
        tx_state_next = wake_pkg::TX_UPDATE; // RL4
        loc_tx_next = tx_temp_reg; // RL5
      end
      wake_pkg::TX_UPDATE: begin
        if (tx_temp_reg >= res_tx_reg || tx_temp_reg >= remote.rem_rx_value) begin
          tx_state_next = wake_pkg::TX_REALLOC; // RL6
          res_tx_next = tx_temp_reg; // RL6
        end else begin
          tx_state_next = wake_pkg::TX_MIRROR; // RL6
        end
      end
      wake_pkg::TX_REALLOC: begin
        tx_state_next = wake_pkg::TX_MIRROR;
      end
      wake_pkg::TX_MIRROR: begin
        rx_echo_next = remote.rem_rx_value; // RL7
        tx_state_next = wake_pkg::TX_RUNNING; // RL7
      end
      default: begin
        tx_state_next = wake_pkg::TX_RUNNING;
      end
    endcase
  end

  // ****************************************************************
  // Receive machine
  // ****************************************************************
  wake_pkg::rx_state_e rx_state_reg;
  wake_pkg::rx_state_e rx_state_next;
  w_t rx_temp_reg;
  w_t rx_temp_next;
  w_t loc_rx_reg;
  w_t loc_rx_next;
  w_t tx_echo_reg;
  w_t tx_echo_next;
  w_t res_rx_reg;
  w_t res_rx_next;
  w_t rem_tx_seen_reg;
  w_t rem_tx_seen_next;
  logic rx_sync;
  w_t rx_extra;

  assign rx_sync = (loc_rx_reg == remote.rem_rx_echo); // RL8
  // Extra remote wake when the PHY extender is to be allowed to halt
  assign rx_extra = phy_extender_stop_req ? w_t'(wake_pkg::XGXS_EXTRA_CYCLES) : '0; // RL17

  always_comb begin
    rx_state_next = rx_state_reg;
    rx_temp_next = rx_temp_reg;
    loc_rx_next = loc_rx_reg;
    tx_echo_next = tx_echo_reg;
    res_rx_next = res_rx_reg;
    rem_tx_seen_next = rem_tx_seen_reg;
    case (rx_state_reg) // RL21
      wake_pkg::RX_RUNNING: begin
        if (local_system_change || remote.rem_tx_value != rem_tx_seen_reg) begin
          rx_state_next = wake_pkg::RX_CHANGE; // RL9
          rem_tx_seen_next = remote.rem_tx_value;
          // Wraps on overflow: proposals near full scale are the user's concern
          rx_temp_next = w_t'(new_rx_value + rx_extra); // RL17
        end
      end
      wake_pkg::RX_CHANGE: begin
        if (rx_temp_reg < res_rx_reg || rx_temp_reg < remote.rem_tx_value) begin
          rx_state_next = wake_pkg::RX_REALLOC; // RL10
          res_rx_next = rx_temp_reg; // RL10
        end else begin
          rx_state_next = wake_pkg::RX_UPDATE; // RL10
          loc_rx_next = rx_temp_reg; // RL11
        end
      end
      wake_pkg::RX_REALLOC: begin
        rx_state_next = wake_pkg::RX_UPDATE; // RL10
        loc_rx_next = rx_temp_reg; // RL11
      end
      wake_pkg::RX_UPDATE: begin
        // Mirror step folded into the exit of RX UPDATE
        tx_echo_next = remote.rem_tx_value; // RL11
        rx_state_next = wake_pkg::RX_RUNNING; // RL11
      end
      default: begin
        rx_state_next = wake_pkg::RX_RUNNING;
      end
    endcase
  end

  // ****************************************************************
  // Low-power idle exit and data hold-off
  // ****************************************************************
  logic lpi_reg;
  logic lpi_next;
  logic pxs_en_reg;
  logic pxs_en_next;
  logic sync_o_reg;
  logic rsync_o_reg;
  logic [wake_pkg::WAKE_W:0] hold_cycles;
  logic hold_ok;

  always_comb begin
    lpi_next = lpi_request; // RL12
    // Stop enable only once the extra remote wake is agreed
    pxs_en_next = phy_extender_stop_req && rx_sync
                  && (loc_rx_reg >= w_t'(wake_pkg::XGXS_EXTRA_CYCLES)); // RL17
    hold_cycles = {1'b0, floor_min(res_tx_reg, phy_min)}; // RL19
    if (dte_extender_stop_enable) begin
      hold_cycles = (wake_pkg::WAKE_W + 1)'(hold_cycles
                    + (wake_pkg::WAKE_W + 1)'(wake_pkg::XGXS_EXTRA_CYCLES)); // RL16
    end
  end

  wake_hold_timer u_hold (
    .sys_clk(sys_clk),
    .reset(reset),
    .start(lpi_reg && !lpi_request), // RL19
    .wait_cycles(hold_cycles),
    .data_ok(hold_ok)
  );

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      fault_cnt_reg <= 32'h0;
      tx_state_reg <= wake_pkg::TX_RUNNING;
      rx_state_reg <= wake_pkg::RX_RUNNING;
      tx_temp_reg <= '0;
      rx_temp_reg <= '0;
      loc_tx_reg <= '0;
      loc_rx_reg <= '0;
      rx_echo_reg <= '0;
      tx_echo_reg <= '0;
      res_tx_reg <= '0; // RL20
      res_rx_reg <= '0; // RL20
      rem_rx_seen_reg <= '0;
      rem_tx_seen_reg <= '0;
      lpi_reg <= 1'b0;
      pxs_en_reg <= 1'b0;
      sync_o_reg <= 1'b0;
      rsync_o_reg <= 1'b0;
    end else begin
      fault_cnt_reg <= fault_cnt_next;
      tx_state_reg <= tx_state_next;
      rx_state_reg <= rx_state_next;
      tx_temp_reg <= tx_temp_next;
      rx_temp_reg <= rx_temp_next;
      // Zero means unset: resolved values then follow the PHY minimum
      loc_tx_reg <= (loc_tx_next == '0) ? phy_min : loc_tx_next; // RL20
      loc_rx_reg <= loc_rx_next;
      rx_echo_reg <= rx_echo_next;
      tx_echo_reg <= tx_echo_next;
      res_tx_reg <= (res_tx_next == '0) ? phy_min : res_tx_next; // RL20
      res_rx_reg <= (res_rx_next == '0) ? phy_min : res_rx_next; // RL20
      rem_rx_seen_reg <= rem_rx_seen_next;
      rem_tx_seen_reg <= rem_tx_seen_next;
      lpi_reg <= lpi_next;
      pxs_en_reg <= pxs_en_next;
      sync_o_reg <= tx_sync;
      rsync_o_reg <= rx_sync;
    end
  end

  assign local_vals = '{loc_tx_value: loc_tx_reg, loc_rx_echo: rx_echo_reg,
                        loc_rx_value: loc_rx_reg, loc_tx_echo: tx_echo_reg};
  assign resolved_tx = res_tx_reg;
  assign resolved_rx = res_rx_reg;
  assign phy_extender_stop_enable = pxs_en_reg;
  assign send_lpi = lpi_reg;
  assign data_allowed = hold_ok && !lpi_reg; // RL19
  assign tx_in_sync = sync_o_reg;
  assign rx_in_sync = rsync_o_reg;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_tx_local_entry: assert property (@(posedge sys_clk) disable iff (reset)
    tx_state_reg == wake_pkg::TX_RUNNING && local_system_change
    |=> tx_state_reg == wake_pkg::TX_LOCAL_CHANGE) // RL2
    else $error("tx did not enter local change");
  a_tx_local_exit: assert property (@(posedge sys_clk) disable iff (reset)
    tx_state_reg == wake_pkg::TX_LOCAL_CHANGE && !(tx_temp_reg < loc_tx_reg) && !tx_sync
    |=> tx_state_reg == wake_pkg::TX_RUNNING) // RL3
    else $error("tx local change wrong exit");
  a_tx_update_load: assert property (@(posedge sys_clk) disable iff (reset)
    tx_state_reg == wake_pkg::TX_UPDATE |-> loc_tx_reg == tx_temp_reg) // RL5
    else $error("advertised tx not proposal");
  a_tx_mirror_back: assert property (@(posedge sys_clk) disable iff (reset)
    tx_state_reg == wake_pkg::TX_MIRROR
    |=> tx_state_reg == wake_pkg::TX_RUNNING && rx_echo_reg == $past(remote.rem_rx_value)) // RL7
    else $error("tx mirror failed");
  a_tx_remote_sync: assert property (@(posedge sys_clk) disable iff (reset)
    tx_state_reg == wake_pkg::TX_RUNNING && !local_system_change && !tx_sync
    |=> tx_state_reg == wake_pkg::TX_RUNNING) // RL4
    else $error("tx acted while out of sync");
  a_rx_change_entry: assert property (@(posedge sys_clk) disable iff (reset)
    rx_state_reg == wake_pkg::RX_RUNNING && local_system_change
    |=> rx_state_reg == wake_pkg::RX_CHANGE ##1 rx_state_reg != wake_pkg::RX_RUNNING) // RL9
    else $error("rx change sequence wrong");
  a_rx_update_load: assert property (@(posedge sys_clk) disable iff (reset)
    rx_state_reg == wake_pkg::RX_UPDATE
    |-> loc_rx_reg == rx_temp_reg ##1 rx_state_reg == wake_pkg::RX_RUNNING) // RL11
    else $error("rx update failed");
  a_data_hold: assert property (@(posedge sys_clk) disable iff (reset)
    $fell(lpi_reg) && res_tx_reg > 16'h0002 |=> !data_allowed [*2]) // RL19
    else $error("data allowed too soon after idle");

endmodule : wake_negotiation
`default_nettype wire

//--- verification/wake_negotiation_tb.sv
// Testbench: wake-time negotiation against the peer model
`timescale 1ns/1ns
`default_nettype none
module wake_negotiation_tb;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [2:0] phy_type;
  logic phy_master, phy_fec, sleep_done, local_fault, dte_stop, lsc, lpi_req, slow;
  wake_pkg::wake_t new_tx, new_rx, req_rx, adv_tx, resolved_tx, resolved_rx, rv;
  wake_pkg::wake_t prev_tx = 16'h0000;
  wake_pkg::wake_t low_cnt = 16'h0000;
  wake_pkg::remote_s remote;
  wake_pkg::local_s local_vals;
  logic send_lpi, data_allowed, tx_sync, rx_sync, pxs_req, pxs_en;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  int seed;
  wake_pkg::wake_t tx_q[$];
  wake_pkg::wake_t hold_q[$];
  logic [2:0] tab_type[9] = '{3'h0, 3'h1, 3'h1, 3'h2, 3'h3, 3'h5, 3'h6, 3'h6, 3'h4};
  logic tab_ms[9] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
  logic tab_fec[9] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
  int tab_ns[9] = '{wake_pkg::TW_100BASE_TX_NS, wake_pkg::TW_1000BASE_T_NS,
    wake_pkg::TW_1000BASE_T_NS, wake_pkg::TW_1000BASE_KX_NS, wake_pkg::TW_XGXS_TX_NS,
    wake_pkg::TW_10GBASE_KX4_NS, wake_pkg::TW_10GBASE_KR_C1_NS,
    wake_pkg::TW_10GBASE_KR_C2_NS, wake_pkg::TW_10GBASE_T_C1_NS};

  always #5 sys_clk = ~sys_clk;

  wake_negotiation #(.FAULT_WINDOW(20)) u_wake_negotiation (
    .sys_clk(sys_clk), .reset(reset), .phy_type(phy_type), .phy_master(phy_master),
    .phy_fec(phy_fec), .sleep_done(sleep_done), .local_fault(local_fault),
    .dte_extender_stop_enable(dte_stop), .phy_extender_stop_req(pxs_req),
    .local_system_change(lsc), .new_tx_value(new_tx), .new_rx_value(new_rx),
    .remote(remote), .lpi_request(lpi_req), .local_vals(local_vals),
    .resolved_tx(resolved_tx), .resolved_rx(resolved_rx), .phy_extender_stop_enable(pxs_en),
    .send_lpi(send_lpi), .data_allowed(data_allowed), .tx_in_sync(tx_sync),
    .rx_in_sync(rx_sync));

  wake_peer_model u_wake_peer_model (
    .sys_clk(sys_clk), .reset(reset), .slow(slow), .req_rx(req_rx), .adv_tx(adv_tx),
    .loc(local_vals), .rem(remote));

  function automatic wake_pkg::wake_t cyc(input int ns, input int floor_ns);
    cyc = wake_pkg::wake_t'(((ns > floor_ns) ? ns : floor_ns) / wake_pkg::CLK_PERIOD_NS);
  endfunction : cyc

  task automatic check(input wake_pkg::wake_t seen, input wake_pkg::wake_t exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t %s seen %0d expected %0d", $time, what, seen, exp);
    end
  endtask : check

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick

  // Local change request; exp is noted only when the update must happen
  task automatic negotiate(input wake_pkg::wake_t v, input wake_pkg::wake_t exp, input logic take);
    if (take) tx_q.push_back(exp);
    new_tx <= v;
    lsc <= 1'b1;
    tick(1);
    lsc <= 1'b0;
    tick(10);
  endtask : negotiate

  // Low-power idle, then leave it and note the expected hold-off
  task automatic hold(input wake_pkg::wake_t exp);
    lpi_req <= 1'b1;
    tick(3);
    #1 check({15'h0000, send_lpi}, 16'h0001, "send_lpi");
    hold_q.push_back(exp);
    tick(1);
    lpi_req <= 1'b0;
    for (int i = 0; i < 5000 && hold_q.size() > 0; i++) tick(1);
    tick(2);
  endtask : hold

  task automatic wait_tx_sync;
    for (int i = 0; i < 600 && tx_sync !== 1'b1; i++) tick(1);
    #1 check({15'h0000, tx_sync}, 16'h0001, "tx sync");
    tick(1);
  endtask : wait_tx_sync

  // ****************************************************************
  // Watcher: outputs are read on the falling edge, where they are settled
  // ****************************************************************
  always @(negedge sys_clk) begin
    cycles++;
    if (cycles > 80000) begin
      mismatches++;
      $display("MISMATCH t=%0t run did not finish", $time);
      give_verdict();
    end else if (!reset) begin
      if (local_vals.loc_tx_value !== prev_tx)
        check(local_vals.loc_tx_value, (tx_q.size() > 0) ? tx_q.pop_front() : prev_tx, "adv tx");
      if (data_allowed === 1'b0 && send_lpi === 1'b0) begin
        low_cnt++;
      end else if (low_cnt != 16'h0000) begin
        check(low_cnt, (hold_q.size() > 0) ? hold_q.pop_front() : 16'h0000, "hold");
        low_cnt = 16'h0000;
      end
    end
    prev_tx = local_vals.loc_tx_value;
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    phy_type = 3'h1;
    phy_master = 1'b1;
    phy_fec = 1'b0;
    sleep_done = 1'b0;
    local_fault = 1'b0;
    dte_stop = 1'b0;
    lsc = 1'b0;
    lpi_req = 1'b0;
    slow = 1'b0;
    pxs_req = 1'b0;
    new_tx = 16'h0000;
    new_rx = 16'h1000;
    req_rx = 16'h0000;
    adv_tx = 16'h0000;
    seed = $urandom(32'hBE73);
    tx_q.push_back(cyc(wake_pkg::TW_1000BASE_T_NS, 0));
    tick(8);
    reset <= 1'b0;
    tick(4);
    #1 check(resolved_tx, cyc(wake_pkg::TW_1000BASE_T_NS, 0), "resolved at start");
    wait_tx_sync();
    $display("test reset defaults done");
    phy_type <= 3'h0;
    hold(cyc(wake_pkg::TW_100BASE_TX_NS, 0));
    dte_stop <= 1'b1;
    hold(cyc(wake_pkg::TW_100BASE_TX_NS + wake_pkg::TW_XGXS_TX_NS - wake_pkg::TW_XGXS_RX_NS, 0));
    dte_stop <= 1'b0;
    $display("test hold-off done");
    phy_type <= 3'h4;
    negotiate(16'h02E0, 16'h02E0, 1'b1);
    #1 check(resolved_tx, 16'h02E0, "resolved lowered");
    tick(1);
    for (int i = 0; i < 9; i++) begin
      phy_type <= tab_type[i];
      phy_master <= tab_ms[i];
      phy_fec <= tab_fec[i];
      tick(2);
      hold(cyc(tab_ns[i], 7360));
    end
    $display("test minimum table done");
    sleep_done <= 1'b1;
    tick(30);
    negotiate(16'h0001, cyc(wake_pkg::TW_10GBASE_T_C2_NS, 0), 1'b1);
    hold(cyc(wake_pkg::TW_10GBASE_T_C2_NS, 0));
    local_fault <= 1'b1;
    tick(1);
    local_fault <= 1'b0;
    hold(cyc(wake_pkg::TW_10GBASE_T_C1_NS, 0));
    tick(30);
    hold(cyc(wake_pkg::TW_10GBASE_T_C2_NS, 0));
    $display("test timing case done");
    slow <= 1'b1;
    negotiate(16'h0300, 16'h0300, 1'b1);
    negotiate(16'h0400, 16'h0000, 1'b0);
    negotiate(16'h02E0, 16'h02E0, 1'b1);
    tx_q.push_back(16'h0900);
    req_rx <= 16'h0800;
    new_tx <= 16'h0900;
    tick(12);
    #1 check(local_vals.loc_rx_echo, 16'h0000, "echo before sync");
    wait_tx_sync();
    slow <= 1'b0;
    tick(20);
    #1 check(local_vals.loc_rx_echo, 16'h0800, "rx echo");
    check(resolved_tx, 16'h0900, "resolved raised");
    tick(1);
    $display("test sync and remote change done");
    rv = 16'h1000 | wake_pkg::wake_t'($urandom & 32'h0FFF);
    new_rx <= rv;
    adv_tx <= 16'h3000;
    tick(12);
    #1 check(local_vals.loc_rx_value, rv, "rx request");
    check(resolved_rx, rv, "resolved rx");
    check(local_vals.loc_tx_echo, 16'h3000, "tx echo");
    tick(10);
    #1 check({15'h0000, rx_sync}, 16'h0001, "rx sync");
    check(wake_pkg::wake_t'(tx_q.size()), 16'h0000, "pending tx notes");
    tick(1);
    // Extender stop request widens the next receive proposal
    pxs_req <= 1'b1;
    adv_tx <= 16'h3100;
    tick(12);
    #1 check(local_vals.loc_rx_value, rv + wake_pkg::wake_t'(wake_pkg::XGXS_EXTRA_CYCLES), "rx extra");
    tick(10);
    #1 check({15'h0000, pxs_en}, 16'h0001, "stop enable");
    check(wake_pkg::wake_t'(hold_q.size()), 16'h0000, "pending hold notes");
    $display("test receive change done");
    give_verdict();
  end
endmodule : wake_negotiation_tb
`default_nettype wire

//--- verification/wake_peer_model.sv
// Peer model: remote link partner that requests, advertises and echoes
`timescale 1ns/1ns
`default_nettype none
module wake_peer_model (
  input wire logic sys_clk, // System clock
  input wire logic reset, // Synchronous reset
  input wire logic slow, // Peer late with its echoes
  input wire logic [wake_pkg::WAKE_W-1:0] req_rx, // Rx wake the peer asks for
  input wire logic [wake_pkg::WAKE_W-1:0] adv_tx, // Tx wake the peer advertises
  input wire wake_pkg::local_s loc, // Values from the device
  output wake_pkg::remote_s rem // Values seen by the device
);
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic differ;
  wake_pkg::remote_s rem_next;
  // ****************************************************************
  // Echo path
  // ****************************************************************
  assign differ = (loc.loc_tx_value != rem.rem_tx_echo) || (loc.loc_rx_value != rem.rem_rx_echo);
  always_comb begin
    rem_next = rem;
    rem_next.rem_rx_value = req_rx;
    rem_next.rem_tx_value = adv_tx;
    cnt_next = differ ? cnt_reg + 8'h01 : 8'h00;
    // A busy peer leaves the device out of sync for a long while
    if (differ && (cnt_reg >= (slow ? 8'hC8 : 8'h02))) begin
      rem_next.rem_tx_echo = loc.loc_tx_value;
      rem_next.rem_rx_echo = loc.loc_rx_value;
      cnt_next = 8'h00;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rem <= '0;
      cnt_reg <= 8'h00;
    end else begin
      rem <= rem_next;
      cnt_reg <= cnt_next;
    end
  end
endmodule : wake_peer_model
`default_nettype wire
